// File: spml_pkg.sv
// Package with register map, field positions and shared types of the serial unit.
// Overview of operation
// - After reset the unit is halted; registers open only once module stop clears.
// - A break sets the framing error flag and possibly the parity error flag.
// - Reception continues after a break, so framing error sets again after clearing.
// - With transmit disabled the transmit pin follows port direction and data latch.
// - Clearing transmit enable resets the transmitter at once and frees the pin.
// - Clocked synchronous transmission never starts while any receive error flag is set.
// - Clearing receive enable leaves the receive error flags set.
// - Module stop resets transmit shift, transmit data and status registers.
// - After mode cancel, enabling transmit drives the transmit line high.
// - A frame cut by a low-power transition is undefined and never completes.
// - Enabling transmit and its request after cancel raises a transmit-empty request.
// - Module stop resets receive shift, receive data and status registers.
// - Leaving clock output mode for asynchronous mode drives the clock pin low for half a bit.
// - A receive error sets an error flag and never sets receive-full.
package spml_pkg;
  // Register byte addresses.
  localparam logic [3:0] ADDR_MODE    = 4'h0;
  localparam logic [3:0] ADDR_BAUD    = 4'h4;
  localparam logic [3:0] ADDR_CTRL    = 4'h8;
  localparam logic [3:0] ADDR_TXDATA  = 4'hC;
  localparam logic [3:0] ADDR_STATUS  = 4'h0;
  localparam logic [3:0] ADDR_RXDATA  = 4'h4;
  localparam logic [3:0] ADDR_STOP    = 4'h8;
  // Word index space: bit 4 selects the second bank.
  localparam logic [4:0] IDX_MODE     = 5'h00;
  localparam logic [4:0] IDX_BAUD     = 5'h04;
  localparam logic [4:0] IDX_CTRL     = 5'h08;
  localparam logic [4:0] IDX_TXDATA   = 5'h0C;
  localparam logic [4:0] IDX_STATUS   = 5'h10;
  localparam logic [4:0] IDX_RXDATA   = 5'h14;
  localparam logic [4:0] IDX_STOP     = 5'h18;
  // Mode register fields.
  localparam int MODE_SYNC = 0;
  localparam int MODE_PAR  = 1;
  localparam int MODE_ODD  = 2;
  localparam int MODE_CKH  = 3;
  localparam int MODE_CKL  = 4;
  // Control register fields.
  localparam int CTRL_TXEN  = 0;
  localparam int CTRL_RXEN  = 1;
  localparam int CTRL_TXIE  = 2;
  localparam int CTRL_ENDIE = 3;
  localparam int CTRL_RIE   = 4;
  localparam int CTRL_DDR   = 5;
  localparam int CTRL_PDAT  = 6;
  // Status register fields.
  localparam int ST_TXE  = 7;
  localparam int ST_RXF  = 6;
  localparam int ST_OVR  = 5;
  localparam int ST_FRM  = 4;
  localparam int ST_PAR  = 3;
  localparam int ST_TEND = 2;
  // Reset values.
  localparam logic [7:0] BAUD_RESET = 8'h0F;
  localparam logic       STOP_RESET = 1'b1;
  // Transfer controller setup time after a data register update, in system cycles.
  localparam int          XFR_SETUP_CYC = 5;
  localparam logic [2:0]  XFR_SETUP     = 3'h5;
  // Line configuration carried from the register file to the engines.
  typedef struct packed {
    logic       sync;
    logic       par_en;
    logic       par_odd;
    logic       ext_clk;
    logic [7:0] baud;
  } spml_cfg_t;
  // Received frame result.
  typedef struct packed {
    logic [7:0] data;
    logic       frm;
    logic       par;
  } spml_rx_t;
endpackage : spml_pkg

// File: spml_tx.sv
// Transmit engine: shift register, start, parity and stop bits, synchronous clock output.
`timescale 1ns/1ps
`default_nettype none
module spml_tx (
  // Clock and reset.
  input  wire logic              mclk,
  input  wire logic              srst,
  // Configuration and control.
  input  wire spml_pkg::spml_cfg_t cfg,
  input  wire logic              enable,
  // Data hand-over.
  input  wire logic              load,
  input  wire logic [7:0]        load_data,
  output var  logic              busy,
  output var  logic              done,
  // Line side.
  input  wire logic              ext_rise,
  input  wire logic              ext_fall,
  output var  logic              txd,
  output var  logic              sck
);
  typedef enum logic [1:0] {S_IDLE, S_SHIFT, S_HALF} spml_tx_state_t;
  spml_tx_state_t state, next_state;
  logic [10:0] shreg, next_shreg;
  logic [3:0]  nbits, next_nbits;
  logic [8:0]  cnt, next_cnt;
  logic        next_txd, next_sck, next_done;

  // Next-state logic; a disable drops everything at once.
  always_comb begin
    next_state = state;
    next_shreg = shreg;
    next_nbits = nbits;
    next_cnt   = cnt;
    next_txd   = txd;
    next_sck   = sck;
    next_done  = 1'b0;
    if (!enable) begin
      next_state = S_IDLE;
      next_txd   = 1'b1;
      next_sck   = 1'b1;
    end else begin
      unique case (state)
        S_IDLE: begin
          if (load) begin
            if (cfg.sync) begin
              next_shreg = {3'h7, load_data};
              next_nbits = 4'h8;
            end else begin
              next_shreg = {2'h3, cfg.par_en ? (^load_data ^ cfg.par_odd) : 1'b1, load_data};
              next_nbits = cfg.par_en ? 4'hB : 4'hA;
              next_txd   = 1'b0;
            end
            next_cnt   = {cfg.baud, 1'b1};
            next_state = cfg.sync ? S_HALF : S_SHIFT;
          end
        end
        S_SHIFT: begin
          if (cnt == 9'h000) begin
            next_nbits = nbits - 4'h1;
            next_cnt   = {cfg.baud, 1'b1};
            if (nbits == 4'h1) begin
              next_state = S_IDLE;
              next_done  = 1'b1;
              next_txd   = 1'b1;
            end else begin
              next_txd   = shreg[0];
              next_shreg = {1'b1, shreg[10:1]};
            end
          end else begin
            next_cnt = cnt - 9'h001;
          end
        end
        S_HALF: begin
          // Synchronous: data changes on falling clock, peer samples on rising.
          if (cfg.ext_clk ? ext_fall : (cnt[7:0] == 8'h00 && sck)) begin
            next_txd   = shreg[0];
            next_shreg = {1'b1, shreg[10:1]};
            next_sck   = cfg.ext_clk ? sck : 1'b0;
            next_cnt   = {1'b0, cfg.baud};
          end else if (cfg.ext_clk ? ext_rise : (cnt[7:0] == 8'h00 && !sck)) begin
            next_sck   = 1'b1;
            next_nbits = nbits - 4'h1;
            next_cnt   = {1'b0, cfg.baud};
            if (nbits == 4'h1) begin
              next_state = S_IDLE;
              next_done  = 1'b1;
            end
          end else begin
            next_cnt = cnt - 9'h001;
          end
        end
      endcase
    end
  end

  // State registers.
  always_ff @(posedge mclk) begin
    if (srst) begin
      state <= S_IDLE;
      shreg <= 11'h7FF;
      nbits <= 4'h0;
      cnt   <= 9'h000;
      txd   <= 1'b1;
      sck   <= 1'b1;
      done  <= 1'b0;
    end else begin
      state <= next_state;
      shreg <= next_shreg;
      nbits <= next_nbits;
      cnt   <= next_cnt;
      txd   <= next_txd;
      sck   <= next_sck;
      done  <= next_done;
    end
  end

  assign busy = (state != S_IDLE);
endmodule : spml_tx
`default_nettype wire

// File: spml_rx.sv
// Receive engine: start detection, mid-bit sampling, parity and framing checks.
`timescale 1ns/1ps
`default_nettype none
module spml_rx (
  // Clock and reset.
  input  wire logic              mclk,
  input  wire logic              srst,
  // Configuration and control.
  input  wire spml_pkg::spml_cfg_t cfg,
  input  wire logic              enable,
  // Line side, already synchronised.
  input  wire logic              rxd,
  input  wire logic              clk_rise,
  // Result.
  output var  logic              got,
  output var  spml_pkg::spml_rx_t result
);
  typedef enum logic [1:0] {S_IDLE, S_START, S_BITS} spml_rx_state_t;
  spml_rx_state_t state, next_state;
  logic [9:0] shreg, next_shreg;
  logic [3:0] nbits, next_nbits;
  logic [8:0] cnt, next_cnt;
  logic       next_got;
  spml_pkg::spml_rx_t next_result;

  // Next-state logic; a line held low simply frames again, so breaks repeat.
  always_comb begin
    next_state  = state;
    next_shreg  = shreg;
    next_nbits  = nbits;
    next_cnt    = cnt;
    next_got    = 1'b0;
    next_result = result;
    if (!enable) begin
      next_state = S_IDLE;
    end else begin
      unique case (state)
        S_IDLE: begin
          if (cfg.sync) begin
            if (clk_rise) begin
              next_shreg = {rxd, shreg[9:1]};
              next_nbits = 4'h1;
              next_state = S_BITS;
            end
          end else if (!rxd) begin
            next_cnt   = {1'b0, cfg.baud};
            next_state = S_START;
          end
        end
        S_START: begin
          if (cnt == 9'h000) begin
            next_cnt   = {cfg.baud, 1'b1};
            next_nbits = 4'h0;
            next_state = rxd ? S_IDLE : S_BITS;
          end else begin
            next_cnt = cnt - 9'h001;
          end
        end
        S_BITS: begin
          if (cfg.sync) begin
            if (clk_rise) begin
              next_shreg = {rxd, shreg[9:1]};
              next_nbits = nbits + 4'h1;
              if (nbits == 4'h7) begin
                next_got         = 1'b1;
                next_result.data = {rxd, shreg[9:3]};
                next_result.frm  = 1'b0;
                next_result.par  = 1'b0;
                next_state       = S_IDLE;
              end
            end
          end else if (cnt == 9'h000) begin
            next_cnt   = {cfg.baud, 1'b1};
            next_nbits = nbits + 4'h1;
            next_shreg = {rxd, shreg[9:1]};
            if (nbits == (cfg.par_en ? 4'h9 : 4'h8)) begin
              next_got         = 1'b1;
              next_state       = S_IDLE;
              next_result.frm  = !rxd;
              next_result.data = cfg.par_en ? shreg[8:1] : shreg[9:2];
              next_result.par  = cfg.par_en & (^shreg[9:1] ^ cfg.par_odd);
            end
          end else begin
            next_cnt = cnt - 9'h001;
          end
        end
        default: next_state = S_IDLE;
      endcase
    end
  end

  // State registers.
  always_ff @(posedge mclk) begin
    if (srst) begin
      state  <= S_IDLE;
      shreg  <= 10'h000;
      nbits  <= 4'h0;
      cnt    <= 9'h000;
      got    <= 1'b0;
      result <= '0;
    end else begin
      state  <= next_state;
      shreg  <= next_shreg;
      nbits  <= next_nbits;
      cnt    <= next_cnt;
      got    <= next_got;
      result <= next_result;
    end
  end
endmodule : spml_rx
`default_nettype wire

// File: spml_top.sv
// Serial unit top: Wishbone register file, module stop, pin muxing and status flags.
`timescale 1ns/1ps
`default_nettype none
module spml_top (
  // Clock and reset.
  input  wire logic        mclk,
  input  wire logic        srst,
  // Wishbone slave.
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [4:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output var  logic [31:0] wb_dat_o,
  output var  logic        wb_ack_o,
  // Serial pins.
  input  wire logic        rxd_pin,
  output var  logic        txd_o,
  output var  logic        txd_oe,
  input  wire logic        sck_i,
  output var  logic        sck_o,
  output var  logic        sck_oe,
  // Requests to the transfer controller and CPU.
  output var  logic        rx_full_request,
  output var  logic        tx_empty_request,
  output var  logic        tx_end_request,
  output var  logic        rx_error_request
);
  // Register file.
  logic [4:0] mode, next_mode;
  logic [7:0] baud, next_baud;
  logic [6:0] ctrl, next_ctrl;
  logic [7:0] tx_data_register, next_tx_data_register;
  logic [7:0] rx_data_register, next_rx_data_register;
  logic [7:0] serial_status_register, next_serial_status_register;
  logic       mstop, next_mstop;
  logic       next_ack;
  logic [31:0] next_dat;
  logic       status_read, next_status_read;
  logic [2:0] setup_cnt, next_setup_cnt;
  logic       sck_low_half, next_sck_low_half;
  logic [8:0] half_cnt, next_half_cnt;
  logic       next_txd_o, next_txd_oe, next_sck_o, next_sck_oe;
  logic       next_rxf, next_txe, next_tend, next_rxe;
  // Synchronisers.
  logic [1:0] rxd_sync, sck_sync;
  logic       sck_prev;
  // Engine wiring.
  spml_pkg::spml_cfg_t cfg;
  spml_pkg::spml_rx_t  rx_res;
  logic       tx_busy, tx_done, tx_line, tx_sck, rx_got, tx_load;
  logic       ext_rise, ext_fall, err_any, wb_req;

  // Two-stage synchronisers for the line inputs; edges come from the second stage only.
  always_ff @(posedge mclk) begin
    if (srst) begin
      rxd_sync <= 2'b11;
      sck_sync <= 2'b11;
      sck_prev <= 1'b1;
    end else begin
      rxd_sync <= {rxd_sync[0], rxd_pin};
      sck_sync <= {sck_sync[0], sck_i};
      sck_prev <= sck_sync[1];
    end
  end

  // Derived controls.
  assign ext_rise = sck_sync[1] & ~sck_prev;
  assign ext_fall = ~sck_sync[1] & sck_prev & (setup_cnt == 3'h0);
  assign err_any  = serial_status_register[spml_pkg::ST_OVR] | serial_status_register[spml_pkg::ST_FRM] |
                    serial_status_register[spml_pkg::ST_PAR];
  assign cfg.sync    = mode[spml_pkg::MODE_SYNC];
  assign cfg.par_en  = mode[spml_pkg::MODE_PAR];
  assign cfg.par_odd = mode[spml_pkg::MODE_ODD];
  assign cfg.ext_clk = mode[spml_pkg::MODE_CKH];
  assign cfg.baud    = baud;
  assign wb_req      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  // Start a frame when data waits, the line is idle and no error blocks sync mode.
  assign tx_load = ~serial_status_register[spml_pkg::ST_TXE] & ~tx_busy & ~tx_done &
                   ~(cfg.sync & err_any);

  spml_tx u_tx (
    .mclk      (mclk),
    .srst      (srst),
    .cfg       (cfg),
    .enable    (ctrl[spml_pkg::CTRL_TXEN] & ~mstop),
    .load      (tx_load),
    .load_data (tx_data_register),
    .busy      (tx_busy),
    .done      (tx_done),
    .ext_rise  (ext_rise),
    .ext_fall  (ext_fall),
    .txd       (tx_line),
    .sck       (tx_sck)
  );

  spml_rx u_rx (
    .mclk     (mclk),
    .srst     (srst),
    .cfg      (cfg),
    .enable   (ctrl[spml_pkg::CTRL_RXEN] & ~mstop),
    .rxd      (rxd_sync[1]),
    .clk_rise (cfg.ext_clk ? ext_rise : (tx_sck & ~sck_o & sck_oe)),
    .got      (rx_got),
    .result   (rx_res)
  );

  // Register, flag and pin next values.
  always_comb begin
    next_mode  = mode;
    next_baud  = baud;
    next_ctrl  = ctrl;
    next_mstop = mstop;
    next_tx_data_register       = tx_data_register;
    next_rx_data_register       = rx_data_register;
    next_serial_status_register = serial_status_register;
    next_status_read = status_read;
    next_ack = wb_req;
    next_dat = 32'h0000_0000;
    next_setup_cnt = (setup_cnt != 3'h0) ? setup_cnt - 3'h1 : 3'h0;
    next_sck_low_half = sck_low_half;
    next_half_cnt = (half_cnt != 9'h000) ? half_cnt - 9'h001 : 9'h000;
    // Bus access; all but the stop register are locked while stopped.
    if (wb_req && wb_we_i && wb_sel_i[0]) begin
      if (wb_adr_i == spml_pkg::IDX_STOP) begin
        next_mstop = wb_dat_i[0];
      end else if (!mstop) begin
        unique case (wb_adr_i)
          spml_pkg::IDX_MODE:   next_mode = wb_dat_i[4:0];
          spml_pkg::IDX_BAUD:   next_baud = wb_dat_i[7:0];
          spml_pkg::IDX_CTRL:   next_ctrl = wb_dat_i[6:0];
          spml_pkg::IDX_TXDATA: begin
            next_tx_data_register = wb_dat_i[7:0];
            next_setup_cnt = spml_pkg::XFR_SETUP;
          end
          spml_pkg::IDX_STATUS: begin
            // Clear-only flags: a zero write clears after a status read.
            if (status_read) begin
              next_serial_status_register = serial_status_register & wb_dat_i[7:0];
              next_serial_status_register[spml_pkg::ST_TEND] = serial_status_register[spml_pkg::ST_TEND];
              next_status_read = 1'b0;
            end
          end
          default: ;
        endcase
      end
    end else if (wb_req && !wb_we_i) begin
      unique case (wb_adr_i)
        spml_pkg::IDX_MODE:   next_dat = {27'h0, mode & {5{~mstop}}};
        spml_pkg::IDX_BAUD:   next_dat = {24'h0, baud & {8{~mstop}}};
        spml_pkg::IDX_CTRL:   next_dat = {25'h0, ctrl & {7{~mstop}}};
        spml_pkg::IDX_TXDATA: next_dat = {24'h0, tx_data_register & {8{~mstop}}};
        spml_pkg::IDX_STATUS: begin
          next_dat = {24'h0, serial_status_register & {8{~mstop}}};
          next_status_read = ~mstop;
        end
        spml_pkg::IDX_RXDATA: begin
          next_dat = {24'h0, rx_data_register & {8{~mstop}}};
          if (!mstop) begin
            next_serial_status_register[spml_pkg::ST_RXF] = 1'b0;
          end
        end
        spml_pkg::IDX_STOP:   next_dat = {31'h0, mstop};
        default:              next_dat = 32'h0000_0000;
      endcase
    end
    // Hardware events come after the bus, so a software clear in the same cycle loses.
    if (tx_load) begin
      next_serial_status_register[spml_pkg::ST_TXE]  = 1'b1;
      next_serial_status_register[spml_pkg::ST_TEND] = 1'b0;
    end
    // Receive results: errors never set receive-full; overrun if unread.
    if (rx_got) begin
      if (serial_status_register[spml_pkg::ST_RXF] || err_any) begin
        next_serial_status_register[spml_pkg::ST_OVR] = 1'b1;
      end else if (rx_res.frm || rx_res.par) begin
        next_serial_status_register[spml_pkg::ST_FRM] = rx_res.frm |
          next_serial_status_register[spml_pkg::ST_FRM];
        next_serial_status_register[spml_pkg::ST_PAR] = rx_res.par |
          next_serial_status_register[spml_pkg::ST_PAR];
      end else begin
        next_rx_data_register = rx_res.data;
        next_serial_status_register[spml_pkg::ST_RXF] = 1'b1;
      end
    end
    if (tx_done && serial_status_register[spml_pkg::ST_TXE]) begin
      next_serial_status_register[spml_pkg::ST_TEND] = 1'b1;
    end
    // Receive enable alone never clears error flags; module stop or a status write after a status read does.
    if (mstop) begin
      next_serial_status_register = 8'h84;
      next_tx_data_register = 8'hFF;
      next_rx_data_register = 8'h00;
    end
    // Clock pin handover: dropping sync mode with clock output gives half a bit low.
    if (mode[spml_pkg::MODE_SYNC] && !next_mode[spml_pkg::MODE_SYNC] && !mode[spml_pkg::MODE_CKH]) begin
      next_sck_low_half = 1'b1;
      next_half_cnt = {1'b0, baud};
    end else if (sck_low_half && half_cnt == 9'h000) begin
      next_sck_low_half = 1'b0;
    end
    // Transmit pin: serial output when enabled, port latch otherwise.
    if (ctrl[spml_pkg::CTRL_TXEN] && !mstop) begin
      next_txd_o  = tx_line;
      next_txd_oe = 1'b1;
    end else begin
      next_txd_o  = ctrl[spml_pkg::CTRL_PDAT];
      next_txd_oe = ctrl[spml_pkg::CTRL_DDR];
    end
    // Clock pin: driven by the unit in sync internal mode, else port or input.
    if (sck_low_half) begin
      next_sck_o  = 1'b0;
      next_sck_oe = 1'b1;
    end else if (mode[spml_pkg::MODE_SYNC] && !mode[spml_pkg::MODE_CKH] && !mstop) begin
      next_sck_o  = tx_sck;
      next_sck_oe = 1'b1;
    end else if (mode[spml_pkg::MODE_SYNC]) begin
      next_sck_o  = 1'b1;
      next_sck_oe = 1'b0;
    end else begin
      next_sck_o  = ctrl[spml_pkg::CTRL_PDAT];
      next_sck_oe = ctrl[spml_pkg::CTRL_DDR];
    end
    // Requests.
    next_txe  = ctrl[spml_pkg::CTRL_TXEN] & ctrl[spml_pkg::CTRL_TXIE] &
                serial_status_register[spml_pkg::ST_TXE] & ~mstop;
    next_tend = ctrl[spml_pkg::CTRL_ENDIE] & serial_status_register[spml_pkg::ST_TEND] & ~mstop;
    next_rxf  = ctrl[spml_pkg::CTRL_RIE] & serial_status_register[spml_pkg::ST_RXF] & ~mstop;
    next_rxe  = ctrl[spml_pkg::CTRL_RIE] & err_any & ~mstop;
  end

  // Register update.
  always_ff @(posedge mclk) begin
    if (srst) begin
      mode  <= 5'h00;
      baud  <= spml_pkg::BAUD_RESET;
      ctrl  <= 7'h00;
      mstop <= spml_pkg::STOP_RESET;
      tx_data_register       <= 8'hFF;
      rx_data_register       <= 8'h00;
      serial_status_register <= 8'h84;
      status_read      <= 1'b0;
      wb_ack_o         <= 1'b0;
      wb_dat_o         <= 32'h0000_0000;
      setup_cnt        <= 3'h0;
      sck_low_half     <= 1'b0;
      half_cnt         <= 9'h000;
      txd_o            <= 1'b1;
      txd_oe           <= 1'b0;
      sck_o            <= 1'b1;
      sck_oe           <= 1'b0;
      rx_full_request  <= 1'b0;
      tx_empty_request <= 1'b0;
      tx_end_request   <= 1'b0;
      rx_error_request <= 1'b0;
    end else begin
      mode  <= next_mode;
      baud  <= next_baud;
      ctrl  <= next_ctrl;
      mstop <= next_mstop;
      tx_data_register       <= next_tx_data_register;
      rx_data_register       <= next_rx_data_register;
      serial_status_register <= next_serial_status_register;
      status_read      <= next_status_read;
      wb_ack_o         <= next_ack;
      wb_dat_o         <= next_dat;
      setup_cnt        <= next_setup_cnt;
      sck_low_half     <= next_sck_low_half;
      half_cnt         <= next_half_cnt;
      txd_o            <= next_txd_o;
      txd_oe           <= next_txd_oe;
      sck_o            <= next_sck_o;
      sck_oe           <= next_sck_oe;
      rx_full_request  <= next_rxf;
      tx_empty_request <= next_txe;
      tx_end_request   <= next_tend;
      rx_error_request <= next_rxe;
    end
  end
endmodule : spml_top
`default_nettype wire

// File: spml_properties.sv
// Checker of bus handshake, reset state and receive requests of the serial unit.
`timescale 1ns/1ps
`default_nettype none
module spml_properties (
  // Watched ports.
  input wire logic        mclk,
  input wire logic        srst,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        txd_oe,
  input wire logic        sck_oe,
  input wire logic        rx_full_request,
  input wire logic        tx_empty_request,
  input wire logic        rx_error_request
);
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  // A request that is taken and not yet answered.
  sequence req_s; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  // An answer that lasts exactly one cycle.
  sequence ack_s; wb_ack_o ##1 !wb_ack_o; endsequence
  ack_timing_a: assert property (req_s |=> wb_ack_o) else $error("ack late");
  ack_once_a: assert property (req_s |=> ack_s) else $error("ack not one pulse");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack unasked");
  idle_no_ack_a: assert property (!wb_stb_i |=> !wb_ack_o) else $error("ack while idle");
  upper_zero_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0) else $error("upper bits set");
  reset_quiet_a: assert property ($fell(srst) |-> !wb_ack_o && !txd_oe && !sck_oe && !rx_full_request
    && !tx_empty_request) else $error("not quiet after reset");
  err_not_full_a: assert property ($rose(rx_error_request) |-> !$rose(rx_full_request))
    else $error("error raised full");
endmodule : spml_properties
bind spml_top spml_properties chk (.mclk(mclk), .srst(srst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .txd_oe(txd_oe), .sck_oe(sck_oe),
  .rx_full_request(rx_full_request), .tx_empty_request(tx_empty_request), .rx_error_request(rx_error_request));
`default_nettype wire

// File: spml_peer.sv
// Remote serial peer: mark or break on the receive line, clock line at rest.
`timescale 1ns/1ps
`default_nettype none
module spml_peer (
  // Control from the bench.
  input wire logic brk,
  // Line side.
  output var logic rxd_pin,
  output var logic sck_i
);
  // The line idles at mark and is held low for a break.
  always_comb begin
    rxd_pin = !brk;
    sck_i   = 1'b1;
  end
endmodule : spml_peer
`default_nettype wire

// File: spml_top_test.sv
// Self-checking bench of the serial unit top.
`timescale 1ns/1ps
`default_nettype none
module spml_top_test;
  logic        mclk, srst, cyc, stb, we, brk, ack, txd, txd_oe, rxf, rxd, sck_i, txe, rxe, sko, skoe;
  logic [4:0]  adr;
  logic [31:0] dat, dat_o;
  logic [7:0]  q;
  int          num_errors, checks_done, ticks;
  spml_peer peer (.brk(brk), .rxd_pin(rxd), .sck_i(sck_i));
  spml_top dut (.mclk(mclk), .srst(srst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'h1), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack), .rxd_pin(rxd), .txd_o(txd),
    .txd_oe(txd_oe), .sck_i(sck_i), .sck_o(sko), .sck_oe(skoe), .rx_full_request(rxf), .tx_empty_request(txe),
    .tx_end_request(), .rx_error_request(rxe));
  // Clock of 5 ns period.
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  // Cuts a hang short.
  always @(posedge mclk) begin
    ticks <= ticks + 1;
    if (ticks == 10000) begin
      num_errors = num_errors + 1;
      final_report();
    end
  end
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  // One classic Wishbone cycle; read data lands in q.
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
    @(posedge mclk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= {24'h0, d};
    do @(posedge mclk); while (ack !== 1'b1);
    q = dat_o[7:0];
    cyc <= 1'b0; stb <= 1'b0;
  endtask : bus
  task automatic stop_test;
    bus(1'b1, spml_pkg::IDX_CTRL, 8'h62);
    bus(1'b0, spml_pkg::IDX_CTRL, 8'h00); chk(q, 8'h00);
    bus(1'b0, spml_pkg::IDX_STOP, 8'h00); chk(q, 8'h01);
    bus(1'b0, 5'h1C, 8'h00); chk(q, 8'h00);
    bus(1'b1, spml_pkg::IDX_STOP, 8'h00);
    bus(1'b0, spml_pkg::IDX_STATUS, 8'h00); chk(q, 8'h84);
  endtask : stop_test
  task automatic break_test;
    bus(1'b1, spml_pkg::IDX_CTRL, 8'h72); repeat (4) @(posedge mclk); chk(8'({txd_oe, txd}), 8'h03);
    brk <= 1'b1; repeat (600) @(posedge mclk);
    bus(1'b0, spml_pkg::IDX_STATUS, 8'h00); chk(8'(q[spml_pkg::ST_FRM]), 8'h01);
    chk(8'(rxf), 8'h00);
    chk(8'(rxe), 8'h01);
    bus(1'b1, spml_pkg::IDX_STATUS, 8'hC7); repeat (600) @(posedge mclk);
    bus(1'b0, spml_pkg::IDX_STATUS, 8'h00); chk(8'(q[spml_pkg::ST_FRM]), 8'h01);
    brk <= 1'b0; bus(1'b1, spml_pkg::IDX_CTRL, 8'h60);
    bus(1'b0, spml_pkg::IDX_STATUS, 8'h00); chk(8'(q[spml_pkg::ST_FRM]), 8'h01);
  endtask : break_test
  task automatic tx_test;
    bus(1'b1, spml_pkg::IDX_CTRL, 8'h25); repeat (4) @(posedge mclk); chk(8'(txd), 8'h01);
    chk(8'(txe), 8'h01);
    bus(1'b1, spml_pkg::IDX_TXDATA, 8'hFF); bus(1'b0, spml_pkg::IDX_STATUS, 8'h00);
    bus(1'b1, spml_pkg::IDX_STATUS, 8'h7F); repeat (100) @(posedge mclk);
    bus(1'b1, spml_pkg::IDX_CTRL, 8'h20); repeat (4) @(posedge mclk);
    chk(8'({txd_oe, txd}), 8'h02);
    bus(1'b1, spml_pkg::IDX_MODE, 8'h01); bus(1'b1, spml_pkg::IDX_CTRL, 8'h21);
    bus(1'b1, spml_pkg::IDX_TXDATA, 8'h5A); bus(1'b0, spml_pkg::IDX_STATUS, 8'h00);
    bus(1'b1, spml_pkg::IDX_STATUS, 8'h7F); repeat (40) @(posedge mclk);
    bus(1'b0, spml_pkg::IDX_STATUS, 8'h00); chk(8'(q[spml_pkg::ST_TXE]), 8'h00);
    bus(1'b1, spml_pkg::IDX_CTRL, 8'h60); bus(1'b1, spml_pkg::IDX_MODE, 8'h00); repeat (2) @(posedge mclk);
    chk(8'({skoe, sko}), 8'h02);
    repeat (40) @(posedge mclk); chk(8'({skoe, sko}), 8'h03);
    bus(1'b1, spml_pkg::IDX_MODE, 8'h01); bus(1'b1, spml_pkg::IDX_MODE, 8'h09);
    bus(1'b1, spml_pkg::IDX_MODE, 8'h08); repeat (2) @(posedge mclk);
    chk(8'({skoe, sko}), 8'h03);
    bus(1'b1, spml_pkg::IDX_MODE, 8'h00);
  endtask : tx_test
  task automatic final_report;
    if (num_errors == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : final_report
  // Main sequence.
  initial begin
    srst = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 5'h00; dat = 32'h0; brk = 1'b0;
    ticks = 0; num_errors = 0; checks_done = 0;
    repeat (8) @(posedge mclk);
    srst <= 1'b0;
    stop_test(); break_test(); tx_test();
    final_report();
  end
endmodule : spml_top_test
`default_nettype wire
